// >>> src/timer5_pkg.sv
package timer5_pkg;

    // ------------------------------------------------------------
    // register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SRC = 8'h04;
    localparam logic [7:0] OFF_CNT_LO = 8'h08;
    localparam logic [7:0] OFF_CNT_HI = 8'h0c;
    localparam logic [7:0] OFF_RC_LO = 8'h10;
    localparam logic [7:0] OFF_RC_HI = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;

    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_RELOAD = 2'h0;
    localparam logic [1:0] MODE_BAUD = 2'h1;
    localparam logic [1:0] MODE_CAP_RISE = 2'h2;
    localparam logic [1:0] MODE_CAP_FALL = 2'h3;

    localparam logic [1:0] PSC_DIV1 = 2'h0;
    localparam logic [1:0] PSC_DIV8 = 2'h1;
    localparam logic [1:0] PSC_DIV64 = 2'h2;
    localparam logic [7:0] PSC_MASK_DIV1 = 8'h00;
    localparam logic [7:0] PSC_MASK_DIV8 = 8'h07;
    localparam logic [7:0] PSC_MASK_DIV64 = 8'h3f;
    localparam logic [7:0] PSC_MASK_DIV256 = 8'hff;

    localparam int SRC_N = 4;
    localparam int IRQ_N = 2;
    localparam int IRQ_OVF = 0;
    localparam int IRQ_EXT = 1;

    typedef struct packed {
        logic overflow_flag;
        logic external_event_flag;
        logic [1:0] prescale_select;
        logic [1:0] mode_select;
        logic run_bit;
        logic external_event_enable;
    } timer_control_t;

    // bit order matches capture_source codes: bit 0 is the timer pin
    typedef struct packed {
        logic uart2_receive_line;
        logic uart1_receive_line;
        logic lfrc_clock;
        logic timer_event_pin;
    } event_inputs_t;

endpackage

// >>> src/timer5_reload_capture.sv
// Notes on behaviour
// - counter overflow sets overflow flag; only a software write of zero clears it.
// - detected enabled external event sets external event flag; software clears it.
// - prescale select divides count clock by 1, 8, 64 or 256.
// - mode select picks auto-reload, baud generator, rising capture or falling capture.
// - run bit zero stops the counter, one lets it count.
// - external event enable zero ignores inputs; one lets edges capture or reload.
// - capture source selects timer pin, low-frequency RC, UART1 or UART2 receive line.
// - count held in low and high byte registers, read/write, reset zero.
// - reload/capture value in low and high byte registers, read/write, reset zero.
// - auto-reload wraps to reload value with overflow; enabled edge forces reload too.
// - baud mode reloads on overflow without interrupt; edges flag without reload.
// - capture modes overflow to zero with flag; qualifying edge captures count.
// - starting the run bit continues from the present count.
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
module timer5_reload_capture (
    input wire logic i_clk, // system clock
    input wire logic i_rst, // async reset, active high
    input wire logic i_wb_cyc, // wishbone cycle
    input wire logic i_wb_stb, // wishbone strobe
    input wire logic i_wb_we, // wishbone write enable
    input wire logic [timer5_pkg::ADDR_W-1:0] i_wb_adr, // byte address
    input wire logic [3:0] i_wb_sel, // byte lane selects
    input wire logic [31:0] i_wb_dat, // write data
    output logic [31:0] o_wb_dat, // read data
    output logic o_wb_ack, // wishbone acknowledge
    input wire timer5_pkg::event_inputs_t i_events, // external event inputs
    output logic o_irq, // level interrupt
    output logic o_baud_tick // one pulse per baud-mode overflow
);
    import timer5_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    timer_control_t ctrl_q, ctrl_d;
    logic [1:0] src_q;
    logic [15:0] count_q, count_d;
    logic [15:0] rcap_q, rcap_d;
    logic [IRQ_N-1:0] stat_q, stat_d;
    logic [IRQ_N-1:0] mask_q;
    logic [7:0] pcnt_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic irq_q;
    logic baud_q;
    logic [SRC_N-1:0] sync1_q, sync2_q, sync3_q;

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic req, wr;
    logic wr_ctrl, wr_src, wr_cnt_lo, wr_cnt_hi, wr_rc_lo, wr_rc_hi, wr_stat, wr_mask;
    logic [7:0] wbyte, rbyte;

    assign req = i_wb_cyc & i_wb_stb;
    assign wr = req & i_wb_we & ack_q & i_wb_sel[0];
    assign wbyte = i_wb_dat[7:0];
    assign wr_ctrl = wr && (i_wb_adr == OFF_CTRL);
    assign wr_src = wr && (i_wb_adr == OFF_SRC);
    assign wr_cnt_lo = wr && (i_wb_adr == OFF_CNT_LO);
    assign wr_cnt_hi = wr && (i_wb_adr == OFF_CNT_HI);
    assign wr_rc_lo = wr && (i_wb_adr == OFF_RC_LO);
    assign wr_rc_hi = wr && (i_wb_adr == OFF_RC_HI);
    assign wr_stat = wr && (i_wb_adr == OFF_IRQ_STAT);
    assign wr_mask = wr && (i_wb_adr == OFF_IRQ_MASK);

    always_comb begin
        case (i_wb_adr)
            OFF_CTRL: rbyte = ctrl_q;
            OFF_SRC: rbyte = {6'h00, src_q};
            OFF_CNT_LO: rbyte = count_q[7:0];
            OFF_CNT_HI: rbyte = count_q[15:8];
            OFF_RC_LO: rbyte = rcap_q[7:0];
            OFF_RC_HI: rbyte = rcap_q[15:8];
            OFF_IRQ_STAT: rbyte = {6'h00, stat_q};
            OFF_IRQ_MASK: rbyte = {6'h00, mask_q};
            default: rbyte = BYTE_RESET;
        endcase
    end

    // ack one cycle after the request, read data sampled with it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q) begin
                rdat_q <= {24'h00_0000, rbyte};
            end
        end
    end

    // ------------------------------------------------------------
    // input synchronisers and edge detect
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SRC_N; gi++) begin : g_sync
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= i_events[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                end
            end
        end
    endgenerate

    logic ev_now, ev_prev, ev_rise, ev_fall, edge_hit;
    logic mode_cap, ext_reload, capture;
    assign ev_now = sync2_q[src_q];
    assign ev_prev = sync3_q[src_q];
    assign ev_rise = ev_now & ~ev_prev;
    assign ev_fall = ~ev_now & ev_prev;
    assign mode_cap = ctrl_q.mode_select[1];

    always_comb begin
        case (ctrl_q.mode_select)
            MODE_CAP_RISE: edge_hit = ev_rise;
            MODE_CAP_FALL: edge_hit = ev_fall;
            default: edge_hit = ev_rise | ev_fall;
        endcase
        if (!ctrl_q.external_event_enable) begin
            edge_hit = 1'b0;
        end
    end
    assign ext_reload = edge_hit && (ctrl_q.mode_select == MODE_RELOAD);
    assign capture = edge_hit && mode_cap;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    logic [7:0] pmask;
    logic tick, wrap, ovf_set;
    always_comb begin
        case (ctrl_q.prescale_select)
            PSC_DIV1: pmask = PSC_MASK_DIV1;
            PSC_DIV8: pmask = PSC_MASK_DIV8;
            PSC_DIV64: pmask = PSC_MASK_DIV64;
            default: pmask = PSC_MASK_DIV256;
        endcase
    end
    assign tick = ctrl_q.run_bit && ((pcnt_q & pmask) == pmask);
    assign wrap = tick && (count_q == COUNT_MAX);
    assign ovf_set = wrap && (ctrl_q.mode_select != MODE_BAUD);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pcnt_q <= BYTE_RESET;
        end else if (ctrl_q.run_bit) begin
            pcnt_q <= pcnt_q + 8'h01;
        end else begin
            pcnt_q <= BYTE_RESET;
        end
    end

    // ------------------------------------------------------------
    // count and reload/capture registers
    // ------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        if (ext_reload) begin
            count_d = rcap_q;
        end else if (wrap) begin
            count_d = mode_cap ? COUNT_ZERO : rcap_q;
        end else if (tick) begin
            count_d = count_q + 16'h0001;
        end
        if (wr_cnt_lo) begin
            count_d[7:0] = wbyte;
        end
        if (wr_cnt_hi) begin
            count_d[15:8] = wbyte;
        end
    end

    always_comb begin
        rcap_d = rcap_q;
        if (capture) begin
            rcap_d = count_q;
        end
        if (wr_rc_lo) begin
            rcap_d[7:0] = wbyte;
        end
        if (wr_rc_hi) begin
            rcap_d[15:8] = wbyte;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count_q <= COUNT_ZERO;
            rcap_q <= COUNT_ZERO;
        end else begin
            count_q <= count_d;
            rcap_q <= rcap_d;
        end
    end

    // ------------------------------------------------------------
    // control, source select, flags
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = wbyte;
        end
        if (ovf_set) begin
            ctrl_d.overflow_flag = 1'b1;
        end
        if (edge_hit) begin
            ctrl_d.external_event_flag = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= BYTE_RESET;
            src_q <= 2'h0;
        end else begin
            ctrl_q <= ctrl_d;
            if (wr_src) begin
                src_q <= wbyte[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status, mask, outputs
    // ------------------------------------------------------------
    always_comb begin
        stat_d = stat_q;
        if (wr_stat) begin
            stat_d = stat_q & ~wbyte[IRQ_N-1:0];
        end
        stat_d[IRQ_OVF] = stat_d[IRQ_OVF] | ovf_set;
        stat_d[IRQ_EXT] = stat_d[IRQ_EXT] | edge_hit;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stat_q <= 2'h0;
            mask_q <= 2'h0;
            irq_q <= 1'b0;
            baud_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            if (wr_mask) begin
                mask_q <= wbyte[IRQ_N-1:0];
            end
            irq_q <= |(stat_d & (wr_mask ? wbyte[IRQ_N-1:0] : mask_q));
            baud_q <= wrap && (ctrl_q.mode_select == MODE_BAUD);
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;
    assign o_irq = irq_q;
    assign o_baud_tick = baud_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_req_start;
        req && !ack_q;
    endsequence

    sequence s_ack_pulse;
        o_wb_ack ##1 !o_wb_ack;
    endsequence

    property p_wb_ack;
        @(posedge i_clk) disable iff (i_rst) s_req_start |=> s_ack_pulse;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("ack not one cycle after request");

    property p_ovf_set;
        @(posedge i_clk) disable iff (i_rst) wrap && ctrl_q.mode_select != MODE_BAUD
            |=> ctrl_q.overflow_flag && stat_q[IRQ_OVF];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow did not set flag");

    property p_ovf_hold;
        @(posedge i_clk) disable iff (i_rst) ctrl_q.overflow_flag && !wr_ctrl
            |=> ctrl_q.overflow_flag;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");

    property p_ext_set;
        @(posedge i_clk) disable iff (i_rst) edge_hit
            |=> ctrl_q.external_event_flag && stat_q[IRQ_EXT];
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("event flag not set");

    property p_div8;
        @(posedge i_clk) disable iff (i_rst)
            tick && ctrl_q.prescale_select == PSC_DIV8 && !wr_ctrl |=> !tick [*7];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by eight ticks early");

    property p_stopped;
        @(posedge i_clk) disable iff (i_rst)
            !ctrl_q.run_bit && !ext_reload && !wr_cnt_lo && !wr_cnt_hi |=> $stable(count_q);
    endproperty
    a_stopped: assert property (p_stopped) else $error("count moved while stopped");

    property p_ignore;
        @(posedge i_clk) disable iff (i_rst)
            !ctrl_q.external_event_enable && !ctrl_q.external_event_flag && !wr_ctrl
            |=> !ctrl_q.external_event_flag;
    endproperty
    a_ignore: assert property (p_ignore) else $error("event seen while disabled");

    property p_reload;
        @(posedge i_clk) disable iff (i_rst)
            wrap && ctrl_q.mode_select == MODE_RELOAD && !wr_cnt_lo && !wr_cnt_hi
            |=> count_q == $past(rcap_q);
    endproperty
    a_reload: assert property (p_reload) else $error("wrap did not reload");

    property p_baud_quiet;
        @(posedge i_clk) disable iff (i_rst)
            wrap && ctrl_q.mode_select == MODE_BAUD && !stat_q[IRQ_OVF]
            |=> !stat_q[IRQ_OVF] && o_baud_tick;
    endproperty
    a_baud_quiet: assert property (p_baud_quiet) else $error("baud overflow raised irq");

    property p_capture;
        @(posedge i_clk) disable iff (i_rst) capture && !wr_rc_lo && !wr_rc_hi
            |=> rcap_q == $past(count_q);
    endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong");

    property p_reserved;
        @(posedge i_clk) disable iff (i_rst) req && !ack_q && i_wb_adr == OFF_SRC
            |=> o_wb_dat[31:2] == 30'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

endmodule

// >>> dv/timer5_event_source.sv
// ------------------------------------------------------------
// event line driver for the timer's external inputs
// ------------------------------------------------------------
module timer5_event_source (
    input wire logic i_clk, // system clock
    output timer5_pkg::event_inputs_t o_events // event lines
);
    import timer5_pkg::*;

    initial o_events = '0;

    // each level held well past the two-flop synchroniser
    task automatic drive(input int idx, input logic v);
        @(posedge i_clk);
        o_events[idx] <= v;
        repeat (6) @(posedge i_clk);
    endtask
endmodule

// >>> dv/test_timer5_reload_capture.sv
module test_timer5_reload_capture;
    timeunit 1ns;
    timeprecision 1ps;
    import timer5_pkg::*;

    logic i_clk, i_rst, cyc, stb, we, ack, irq, btick;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    event_inputs_t ev;
    int error_cnt, checks, cycles, ticks;
    logic [7:0] psc_exp [4] = '{8'hcb, 8'h19, 8'h03, 8'h00};

    timer5_reload_capture dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_events(ev), .o_irq(irq), .o_baud_tick(btick)
    );

    timer5_event_source ev_u (.i_clk(i_clk), .o_events(ev));

    // ------------------------------------------------------------
    // clock, timeout, tick counting
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cycles++;
        if (btick === 1'b1) ticks++;
        if (cycles == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= 1'b1;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h000000, d};
        do @(posedge i_clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= 1'b0;
        adr <= a;
        sel <= 4'hf;
        do @(posedge i_clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        chk(rdat, {24'h000000, exp});
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        {cyc, stb, we, adr, sel, wdat} = '0;
        i_rst = 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd_chk(8'(i * 4), 8'h00);
        rd_chk(8'h20, 8'h00);
        wr(OFF_SRC, 8'hff);
        rd_chk(OFF_SRC, 8'h03);
        // auto-reload overflow, sticky flag, masking
        wr(OFF_CNT_LO, 8'hfe);
        wr(OFF_CNT_HI, 8'hff);
        wr(OFF_RC_LO, 8'h34);
        wr(OFF_RC_HI, 8'h12);
        wr(OFF_CTRL, 8'h02);
        repeat (6) @(posedge i_clk);
        wr(OFF_CTRL, 8'h80);
        rd_chk(OFF_CTRL, 8'h80);
        rd_chk(OFF_CNT_HI, 8'h12);
        rd_chk(OFF_CNT_LO, 8'h3b);
        rd_chk(OFF_IRQ_STAT, 8'h01);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_IRQ_MASK, 8'h03);
        repeat (2) @(posedge i_clk);
        chk({31'h0, irq}, 32'h1);
        wr(OFF_IRQ_STAT, 8'h01);
        repeat (2) @(posedge i_clk);
        chk({31'h0, irq}, 32'h0);
        rd_chk(OFF_CTRL, 8'h80);
        // prescaler ratios over a fixed run window
        for (int p = 0; p < 4; p++) begin
            wr(OFF_CNT_LO, 8'h00);
            wr(OFF_CNT_HI, 8'h00);
            wr(OFF_CTRL, {2'b00, 2'(p), 4'b0010});
            repeat (200) @(posedge i_clk);
            wr(OFF_CTRL, 8'h00);
            rd_chk(OFF_CNT_LO, psc_exp[p]);
            repeat (20) @(posedge i_clk);
            rd_chk(OFF_CNT_LO, psc_exp[p]);
        end
        // baud mode: reload, tick, no overflow flag
        wr(OFF_CNT_LO, 8'hfe);
        wr(OFF_CNT_HI, 8'hff);
        wr(OFF_RC_LO, 8'h00);
        wr(OFF_RC_HI, 8'hf0);
        ticks = 0;
        wr(OFF_CTRL, 8'h06);
        repeat (10) @(posedge i_clk);
        wr(OFF_CTRL, 8'h04);
        rd_chk(OFF_CTRL, 8'h04);
        rd_chk(OFF_IRQ_STAT, 8'h00);
        rd_chk(OFF_CNT_HI, 8'hf0);
        chk(32'(ticks), 32'h1);
        // edge-forced reload in auto-reload mode
        wr(OFF_SRC, 8'h00);
        wr(OFF_CNT_HI, 8'h00);
        wr(OFF_CTRL, 8'h01);
        ev_u.drive(0, 1'b1);
        rd_chk(OFF_CTRL, 8'h41);
        rd_chk(OFF_CNT_HI, 8'hf0);
        ev_u.drive(0, 1'b0);
        // baud mode: edges flag without reload
        wr(OFF_CNT_HI, 8'h00);
        wr(OFF_CTRL, 8'h05);
        ev_u.drive(0, 1'b1);
        rd_chk(OFF_CTRL, 8'h45);
        rd_chk(OFF_CNT_HI, 8'h00);
        ev_u.drive(0, 1'b0);
        // capture from every source, both edge modes
        for (int s = 0; s < 4; s++) begin
            wr(OFF_SRC, 8'(s));
            wr(OFF_CNT_LO, 8'(8'h30 + s));
            wr(OFF_CNT_HI, 8'ha5);
            wr(OFF_RC_LO, 8'h00);
            wr(OFF_RC_HI, 8'h00);
            wr(OFF_IRQ_STAT, 8'h03);
            wr(OFF_CTRL, 8'h08);
            ev_u.drive(s, 1'b1);
            rd_chk(OFF_CTRL, 8'h08);
            wr(OFF_CTRL, 8'h0d);
            ev_u.drive(s, 1'b0);
            rd_chk(OFF_CTRL, 8'h4d);
            rd_chk(OFF_RC_LO, 8'(8'h30 + s));
            rd_chk(OFF_IRQ_STAT, 8'h02);
            chk({31'h0, irq}, 32'h1);
            wr(OFF_RC_HI, 8'h00);
            wr(OFF_CTRL, 8'h09);
            ev_u.drive(s, 1'b1);
            rd_chk(OFF_CTRL, 8'h49);
            rd_chk(OFF_RC_HI, 8'ha5);
            ev_u.drive(s, 1'b0);
        end
        // capture mode overflow: wraps to zero, no reload
        wr(OFF_IRQ_STAT, 8'h03);
        wr(OFF_CNT_LO, 8'hfe);
        wr(OFF_CNT_HI, 8'hff);
        wr(OFF_RC_LO, 8'h55);
        wr(OFF_CTRL, 8'h0a);
        wr(OFF_CTRL, 8'h08);
        rd_chk(OFF_CTRL, 8'h08);
        rd_chk(OFF_CNT_HI, 8'h00);
        rd_chk(OFF_CNT_LO, 8'h01);
        rd_chk(OFF_IRQ_STAT, 8'h01);
        wrap_up();
    end
endmodule
